// *** src/icc_regs.svh ***
// Constants for the input capture conditioning block
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH
`define ICC_CLK_MHZ 200
`define ICC_CATCH_MIN_US 10
`define ICC_CATCH_MIN_CYC ((`ICC_CATCH_MIN_US * `ICC_CLK_MHZ) < 1 ? 1 : (`ICC_CATCH_MIN_US * `ICC_CLK_MHZ))
`define ICC_MS_CYC (`ICC_CLK_MHZ * 1000)
`define ICC_FILT_RESET_SEL 4'h4
`define ICC_FILT_RESET_MS 10
`define ICC_NUM_INPUTS 8
`define ICC_ECON_INPUTS 4
`define ICC_EDGE_RISE 2'h0
`define ICC_EDGE_FALL 2'h1
`define ICC_EDGE_BOTH 2'h2
`endif

// *** src/icc_pkg.sv ***
// Types for the input capture conditioning block
package icc_pkg;
	typedef logic [1:0] icc_edge_t;
	typedef enum logic [2:0] {
		ICC_IDLE = 3'b001,
		ICC_HOLD = 3'b010,
		ICC_SHOW = 3'b100
	} icc_catch_t;
endpackage

// *** src/icc_chan_if.sv ***
// Per-input signals between the top and one input channel
`timescale 1ns/1ps
`default_nettype none
interface icc_chan_if;
	logic raw;
	logic scan_tick;
	logic catch_en;
	logic econ;
	logic int_en;
	logic [1:0] edge_sel;
	logic filt_tick;
	logic [31:0] filt_len;
	logic image;
	logic irq;
	modport chan (input raw, scan_tick, catch_en, econ, int_en, edge_sel, filt_tick, filt_len,
		output image, irq);
	modport top (output raw, scan_tick, catch_en, econ, int_en, edge_sel, filt_tick, filt_len,
		input image, irq);
endinterface
`default_nettype wire

// *** src/icc_chan.sv ***
// One input channel: synchroniser, pulse catch, delay filter, edge interrupt
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"
module icc_chan (
	input wire logic mclk,
	input wire logic rst,
	icc_chan_if.chan ch
);
	typedef struct packed {
		logic s1, s2, s3;
		logic lvl;
		logic filt;
		logic [31:0] cnt;
		icc_pkg::icc_catch_t cst;
		logic image;
		logic irq;
	} icc_chan_st_t;
	icc_chan_st_t q_r, q_nxt;
	logic rise, fall, hit;

	// Edge of the synchronised level, seen once s2 and s3 agree on the new value
	always_comb begin
		rise = (q_r.s2 == q_r.s3) & q_r.s3 & ~q_r.lvl;
		fall = (q_r.s2 == q_r.s3) & ~q_r.s3 & q_r.lvl;
		hit = 1'b0;
		q_nxt = q_r;
		q_nxt.s1 = ch.raw;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		// Agreed level moves only when the last two stages match
		q_nxt.lvl = (q_r.s2 == q_r.s3) ? q_r.s3 : q_r.lvl;
		q_nxt.irq = 1'b0;
		// Delay filter: new level must persist the configured time
		// One tick more than the delay, since the first tick lands anywhere in the first ms
		if (q_r.lvl == q_r.filt) begin
			q_nxt.cnt = '0;
		end else if (ch.filt_len == 32'h0000_0000 || q_r.cnt > ch.filt_len) begin
			q_nxt.filt = q_r.lvl;
			q_nxt.cnt = '0;
		end else if (ch.filt_tick) begin
			q_nxt.cnt = q_r.cnt + 32'h0000_0001;
		end
		// Interrupt launches at once, not on the scan
		if (ch.int_en) begin
			if (ch.econ) begin
				hit = rise;
			end else begin
				case (ch.edge_sel)
					`ICC_EDGE_RISE: hit = rise;
					`ICC_EDGE_FALL: hit = fall;
					`ICC_EDGE_BOTH: hit = rise | fall;
					default: hit = rise;
				endcase
			end
		end
		q_nxt.irq = hit;
		// Pulse catch: hold, show one scan, clear next scan
		case (q_r.cst)
			icc_pkg::ICC_IDLE: begin
				if (ch.catch_en && rise) begin
					q_nxt.cst = icc_pkg::ICC_HOLD;
				end
			end
			icc_pkg::ICC_HOLD: begin
				if (ch.scan_tick) begin
					q_nxt.cst = icc_pkg::ICC_SHOW;
				end
			end
			icc_pkg::ICC_SHOW: begin
				if (ch.scan_tick) begin
					q_nxt.cst = icc_pkg::ICC_IDLE;
				end
			end
			default: q_nxt.cst = icc_pkg::ICC_IDLE;
		endcase
		if (!ch.catch_en) begin
			q_nxt.cst = icc_pkg::ICC_IDLE;
		end
		// Image updates only at the scan boundary
		if (ch.scan_tick) begin
			q_nxt.image = ch.catch_en ? (q_r.cst == icc_pkg::ICC_HOLD) | q_nxt.filt : q_nxt.filt;
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_r <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, lvl: 1'b0, filt: 1'b0, cnt: 32'h0000_0000,
				cst: icc_pkg::ICC_IDLE, image: 1'b0, irq: 1'b0};
		end else begin
			q_r <= q_nxt;
		end
	end
	assign ch.image = q_r.image;
	assign ch.irq = q_r.irq;

	// A caught pulse reaches the image on the first scan boundary after it was held
	catch_shows_a: assert property (@(posedge mclk) disable iff (rst)
		(q_r.cst == icc_pkg::ICC_HOLD && ch.scan_tick && ch.catch_en) |=> q_r.image)
		else $error("caught pulse not shown in image");
	// Interrupt follows either edge in one cycle when both edges are selected on the standard variant
	edge_irq_a: assert property (@(posedge mclk) disable iff (rst)
		(ch.int_en && !ch.econ && ch.edge_sel == `ICC_EDGE_BOTH && (rise || fall)) |=> q_r.irq)
		else $error("edge did not raise interrupt");
	// Economic variant never fires on a falling edge
	econ_rise_a: assert property (@(posedge mclk) disable iff (rst)
		(ch.econ && fall) |=> !q_r.irq)
		else $error("falling edge fired on economic variant");
	// Filter output never moves without a settled disagreement
	filt_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(q_r.lvl == q_r.filt) |=> $stable(q_r.filt))
		else $error("filter changed without input change");
	// Undesignated inputs never hold a catch
	catch_off_a: assert property (@(posedge mclk) disable iff (rst)
		!ch.catch_en |=> q_r.cst == icc_pkg::ICC_IDLE)
		else $error("catch active while not designated");
endmodule // icc_chan
`default_nettype wire

// *** src/icc_top.sv ***
// Input capture conditioning top: eight inputs, shared filter, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"
module icc_top #(
	parameter int N = `ICC_NUM_INPUTS,
	parameter int MS_CYC = `ICC_MS_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [N-1:0] main_unit_inputs,
	input wire logic scan_tick,
	input wire logic econ,
	input wire logic [N-1:0] catch_sel,
	input wire logic [N-1:0] int_sel,
	input wire logic [2*N-1:0] edge_sel,
	input wire logic [3*N-1:0] int_prio,
	input wire logic [4*N-1:0] int_task,
	input wire logic [3:0] other_irq_count,
	input wire logic [3:0] filt_sel,
	input wire logic filt_load,
	output logic [N-1:0] input_image,
	output logic irq_valid,
	output logic [3:0] irq_task,
	output logic [2:0] irq_prio,
	output logic [3:0] irq_slots,
	output logic [3:0] filt_sel_now
);
	typedef struct packed {
		logic [3:0] fsel;
		logic [31:0] mcnt;
		logic ftick;
		logic [N-1:0] image;
		logic irq_valid;
		logic [3:0] irq_task;
		logic [2:0] irq_prio;
		logic [3:0] slots;
	} icc_top_st_t;
	icc_top_st_t q_r, q_nxt;
	logic [N-1:0] ch_image, ch_irq, usable;
	logic [31:0] flen;
	int lim;

	// Filter delay lookup in milliseconds
	// Codes past the list fall back to the reset entry; the load path refuses them anyway
	function automatic logic [31:0] icc_ms(input logic [3:0] s);
		case (s)
			4'h0: icc_ms = 32'd0;
			4'h1: icc_ms = 32'd1;
			4'h2: icc_ms = 32'd2;
			4'h3: icc_ms = 32'd5;
			4'h4: icc_ms = 32'd10;
			4'h5: icc_ms = 32'd20;
			4'h6: icc_ms = 32'd50;
			4'h7: icc_ms = 32'd100;
			4'h8: icc_ms = 32'd200;
			4'h9: icc_ms = 32'd500;
			4'ha: icc_ms = 32'd1000;
			default: icc_ms = 32'd10;
		endcase
	endfunction
	assign flen = icc_ms(q_r.fsel);

	// Usable interrupt inputs: variant limit less other sources
	// Other sources take the top slots first, so the low inputs stay usable
	always_comb begin
		lim = (econ ? `ICC_ECON_INPUTS : N) - int'(other_irq_count);
		for (int i = 0; i < N; i++) begin
			usable[i] = int_sel[i] && (i < lim);
		end
	end

	// One channel per input, all sharing one filter setting
	// Gating is done here so a channel never sees an input it may not use
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_ch
			icc_chan_if cif ();
			assign cif.raw = main_unit_inputs[g];
			assign cif.scan_tick = scan_tick;
			assign cif.catch_en = catch_sel[g] && (!econ || g < `ICC_ECON_INPUTS);
			assign cif.econ = econ;
			assign cif.int_en = usable[g];
			assign cif.edge_sel = edge_sel[2*g +: 2];
			assign cif.filt_tick = q_r.ftick;
			assign cif.filt_len = flen;
			assign ch_image[g] = cif.image;
			assign ch_irq[g] = cif.irq;
			icc_chan u_chan (
				.mclk(mclk),
				.rst(rst),
				.ch(cif)
			);

			// Economic variant gates catch and interrupt off on the upper inputs
			econ_gate_a: assert property (@(posedge mclk) disable iff (rst)
				(econ && g >= `ICC_ECON_INPUTS) |-> (!cif.catch_en && !cif.int_en))
				else $error("upper input enabled on economic variant");

			// Other sources take the highest interrupt inputs first
			slot_taken_a: assert property (@(posedge mclk) disable iff (rst)
				(int'(other_irq_count) + g >= N) |-> !cif.int_en)
				else $error("interrupt input enabled beyond free slots");

			// The winner never has a worse number than any firing input
			prio_win_a: assert property (@(posedge mclk) disable iff (rst)
				ch_irq[g] |=> q_r.irq_prio <= $past(int_prio[3*g +: 3]))
				else $error("interrupt lost to a worse priority");

			// A lone firing input hands over its own task
			task_lone_a: assert property (@(posedge mclk) disable iff (rst)
				(ch_irq[g] && $onehot(ch_irq)) |=> q_r.irq_task == $past(int_task[4*g +: 4]))
				else $error("interrupt carried the wrong task");
		end
	endgenerate

	// Millisecond tick, filter select, interrupt arbitration by priority
	// One tick shared by every channel keeps all delays on one time base
	always_comb begin
		q_nxt = q_r;
		q_nxt.ftick = 1'b0;
		if (q_r.mcnt >= 32'(MS_CYC - 1)) begin
			q_nxt.mcnt = '0;
			q_nxt.ftick = 1'b1;
		end else begin
			q_nxt.mcnt = q_r.mcnt + 32'h0000_0001;
		end
		if (filt_load && filt_sel <= 4'ha) begin
			q_nxt.fsel = filt_sel;
		end
		q_nxt.image = ch_image;
		q_nxt.slots = 4'(lim < 0 ? 0 : lim);
		q_nxt.irq_valid = 1'b0;
		// Lowest priority number wins; lowest index breaks ties
		// Losers are dropped, not queued: nothing is buffered here
		for (int i = N - 1; i >= 0; i--) begin
			if (ch_irq[i] && (!q_nxt.irq_valid || int_prio[3*i +: 3] <= q_nxt.irq_prio)) begin
				q_nxt.irq_valid = 1'b1;
				q_nxt.irq_prio = int_prio[3*i +: 3];
				q_nxt.irq_task = int_task[4*i +: 4];
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_r <= '{fsel: `ICC_FILT_RESET_SEL, mcnt: 32'h0000_0000, ftick: 1'b0,
				image: '0, irq_valid: 1'b0, irq_task: 4'h0, irq_prio: 3'h0, slots: 4'h0};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign input_image = q_r.image;
	assign irq_valid = q_r.irq_valid;
	assign irq_task = q_r.irq_task;
	assign irq_prio = q_r.irq_prio;
	assign irq_slots = q_r.slots;
	assign filt_sel_now = q_r.fsel;

	// Filter selection resets to the 10 ms entry
	filt_reset_a: assert property (@(posedge mclk) $fell(rst) |-> q_r.fsel == 4'h4)
		else $error("filter select not at reset value");
	// Out-of-list selections are refused
	filt_list_a: assert property (@(posedge mclk) disable iff (rst)
		(filt_load && filt_sel > 4'ha) |=> $stable(q_r.fsel))
		else $error("illegal filter selection accepted");
	// Any channel interrupt yields an interrupt pulse
	irq_one_a: assert property (@(posedge mclk) disable iff (rst)
		(|ch_irq) |=> q_r.irq_valid)
		else $error("channel interrupt lost");

	// Slot count on the standard variant with no other sources
	slots_std_a: assert property (@(posedge mclk) disable iff (rst)
		(!econ && other_irq_count == 4'h0) |=> q_r.slots == 4'(N))
		else $error("standard slot count wrong");

	// Slot count on the economic variant with no other sources
	slots_econ_a: assert property (@(posedge mclk) disable iff (rst)
		(econ && other_irq_count == 4'h0) |=> q_r.slots == 4'(`ICC_ECON_INPUTS))
		else $error("economic slot count wrong");

	// One other source takes one slot away on the standard variant
	slots_less_a: assert property (@(posedge mclk) disable iff (rst)
		(!econ && other_irq_count == 4'h1) |=> q_r.slots == 4'(N - 1))
		else $error("other source did not take a slot");

	// No channel interrupt, no pulse out
	irq_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		!(|ch_irq) |=> !q_r.irq_valid)
		else $error("interrupt pulse without a source");

	// Legal selections land on the next edge
	filt_load_a: assert property (@(posedge mclk) disable iff (rst)
		(filt_load && filt_sel <= 4'ha) |=> q_r.fsel == $past(filt_sel))
		else $error("legal filter selection not taken");

	// Millisecond tick is a lone pulse; needs MS_CYC above one
	tick_single_a: assert property (@(posedge mclk) disable iff (rst)
		q_r.ftick |=> !q_r.ftick)
		else $error("filter tick longer than one cycle");

	// Shared tick counter never runs past one millisecond
	mcnt_range_a: assert property (@(posedge mclk) disable iff (rst)
		q_r.mcnt < 32'(MS_CYC))
		else $error("millisecond counter out of range");
endmodule // icc_top
`default_nettype wire

// *** verif/icc_scan_model.sv ***
// Scan engine model that marks scan boundaries on request
`timescale 1ns/1ps
`default_nettype none
module icc_scan_model (
	output logic scan_tick,
	input wire logic mclk
);
	initial scan_tick = 1'b0;
	// One-cycle boundary, then room for the image to settle
	task automatic scan();
		@(negedge mclk);
		scan_tick = 1'b1;
		@(negedge mclk);
		scan_tick = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
endmodule // icc_scan_model
`default_nettype wire

// *** verif/input_capture_conditioning_tb.sv ***
// Self-checking bench for the input capture conditioning block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module input_capture_conditioning_tb;
	logic mclk = 1'b0, rst = 1'b1, econ = 1'b0, filt_load = 1'b0, scan_tick, irq_valid;
	logic [7:0] raw = 8'h00, catch_sel = 8'h00, int_sel = 8'h00, image, got;
	logic [15:0] edge_sel = 16'h0000;
	logic [23:0] int_prio = 24'h00_0000;
	logic [31:0] int_task = 32'h7654_3210;
	logic [3:0] other = 4'h0, filt_sel = 4'h0, irq_task, irq_slots, filt_now;
	logic [2:0] irq_prio;
	logic [31:0] seed = 32'h0000_4f25;
	int mismatches = 0, check_count = 0;
	// Free-running 200 MHz clock
	always #2.5 mclk = ~mclk;
	icc_top #(.N(8), .MS_CYC(20)) icc_top_inst (.mclk(mclk), .rst(rst), .main_unit_inputs(raw),
		.scan_tick(scan_tick), .econ(econ), .catch_sel(catch_sel), .int_sel(int_sel),
		.edge_sel(edge_sel), .int_prio(int_prio), .int_task(int_task), .other_irq_count(other),
		.filt_sel(filt_sel), .filt_load(filt_load), .input_image(image), .irq_valid(irq_valid),
		.irq_task(irq_task), .irq_prio(irq_prio), .irq_slots(irq_slots), .filt_sel_now(filt_now));
	icc_scan_model icc_scan_model_inst (.scan_tick(scan_tick), .mclk(mclk));
	// Xorshift step for repeatable random contact patterns
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wrap_up();
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic load(input logic [3:0] code);
		@(negedge mclk);
		filt_sel = code;
		filt_load = 1'b1;
		@(negedge mclk);
		filt_load = 1'b0;
		@(negedge mclk);
	endtask
	task automatic hold(input logic [7:0] v, input int n);
		@(negedge mclk);
		raw = v;
		repeat (n) @(negedge mclk);
	endtask
	// Fixed observation window; returns {seen, prio, task} of the first pulse
	task automatic wait_irq(output logic [7:0] r);
		r = 8'h00;
		for (int i = 0; i < 16; i++) begin
			@(negedge mclk);
			if (irq_valid === 1'b1 && r[7] !== 1'b1)
				r = {1'b1, irq_prio, irq_task};
		end
	endtask
	initial begin
		for (int i = 0; i < 8; i++)
			int_prio[3*i+:3] = 3'(7 - i);
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		`CHK(filt_now, 4'h4)
		`CHK(image, 8'h00)
		// Every listed delay code is taken, a code past the list is ignored
		for (int c = 0; c <= 11; c++) begin
			load(c[3:0]);
			`CHK(filt_now, (c > 10) ? 4'ha : c[3:0])
		end
		// One shared 1 ms delay: long levels pass, short glitches do not
		load(4'h1);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			hold(seed[7:0], 60);
			icc_scan_model_inst.scan();
			`CHK(image, seed[7:0])
			hold(~seed[7:0], 12);
			icc_scan_model_inst.scan();
			`CHK(image, seed[7:0])
		end
		hold(8'h00, 60);
		icc_scan_model_inst.scan();
		// Slow filter so only caught inputs can see a narrow pulse
		load(4'h4);
		catch_sel = 8'h11;
		for (int e = 0; e < 2; e++) begin
			econ = e[0];
			hold(8'h13, 4);
			hold(8'h00, 20);
			icc_scan_model_inst.scan();
			`CHK(image, e ? 8'h01 : 8'h11)
			icc_scan_model_inst.scan();
			`CHK(image, 8'h00)
		end
		catch_sel = 8'h00;
		load(4'h0);
		// Usable interrupt count per variant and other sources
		for (int o = 0; o < 4; o++)
			for (int e = 0; e < 2; e++) begin
				econ = e[0];
				other = o[3:0];
				repeat (3) @(negedge mclk);
				`CHK(irq_slots, 4'((e ? 4 : 8) - o))
			end
		other = 4'h0;
		int_sel = 8'hff;
		// Each edge mode on both variants, rising then falling contact
		for (int m = 0; m < 3; m++)
			for (int e = 0; e < 2; e++) begin
				econ = e[0];
				edge_sel = {8{m[1:0]}};
				hold(8'h08, 0);
				wait_irq(got);
				`CHK(got, ((e || m != 1) ? 8'hc3 : 8'h00))
				hold(8'h00, 0);
				wait_irq(got);
				`CHK(got, ((e == 0 && m != 0) ? 8'hc3 : 8'h00))
			end
		// Simultaneous edges: index 7 is out of range, input 5 outranks 1
		econ = 1'b0;
		other = 4'h1;
		edge_sel = 16'h0000;
		hold(8'ha2, 0);
		wait_irq(got);
		`CHK(got, 8'ha5)
		wrap_up();
	end
endmodule // input_capture_conditioning_tb
`default_nettype wire
